// ---- tsr_supervisor.sv ----
// Trip auto-restart supervisor: decides alarm, 0 Hz restart or matched restart.
// Assumes fault inputs and motor frequency synchronous to clock_i; register
// port with read data in the cycle after the read strobe.
//
// Behaviour
// [R1] Over-current trips allow at most three restart attempts.
// [R2] Over-voltage trips allow at most three restart attempts.
// [R3] Under-voltage trips allow sixteen restarts unless unlimited is configured.
// [R4] At the limit, stay tripped until reset by power cycle.
// [R5] Method 00 alarms without restart; method 01 restarts at 0 Hz.
// [R6] Method 02 matches motor frequency, then resumes normal running.
// [R7] Method 03 matches, resumes, decelerates to stop, then shows trip info.
// [R8] Matching starts output at the frequency derived from residual flux.
// [R9] Under-voltage longer than ride-through time trips; range 0.3 to 1.0 s.
// [R10] Under-voltage ending within ride-through leads to a retry.
// [R11] Wait the retry delay after the trip clears; range 0.3 to 100 s.
// [R12] Under-voltage alarm: 00 off, 01 on, 02 off while stopping.
// [R13] Under-voltage restart count: 00 sixteen, 01 unlimited.
// [R14] Phase loss: 00 never trips, 01 trips on detection.
// [R15] Motor below threshold restarts at 0 Hz instead of matching.
// [R16] Separate attempt counter per trip kind compared to its own limit.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tsr_supervisor #(
  parameter int unsigned TICK_CYC = tsr_pkg::TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire tsr_pkg::tsr_faults_t faults_i,
  input wire logic [15:0] motor_freq_i,
  input wire logic stopping_i,
  input wire logic stopped_i,
  input wire logic fault_reset_i,
  output tsr_pkg::tsr_drive_t drive_o
);
  import tsr_pkg::*;

  typedef struct packed {
    tsr_state_t st;
    tsr_cfg_t cfg;
    logic [31:0] pre;
    logic [3:0] ride_cnt;
    logic [9:0] wait_cnt;
    logic [31:0] rdata;
    tsr_drive_t drive;
  } tsr_sup_t;

  tsr_sup_t s;
  tsr_sup_t next_s;
  logic tick;
  logic inc_oc;
  logic inc_ov;
  logic inc_uv;
  logic oc_at;
  logic ov_at;
  logic uv_at;
  logic [4:0] oc_cnt;
  logic [4:0] ov_cnt;
  logic [4:0] uv_cnt;
  logic uv_alarm;
  logic uv_blocked;
  logic [15:0] match_freq;

  tsr_attempt_ctr #(.W(5)) u_oc_ctr (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .inc_i(inc_oc),
    .limit_i(OC_LIMIT),
    .count_o(oc_cnt),
    .at_limit_o(oc_at)
  );

  tsr_attempt_ctr #(.W(5)) u_ov_ctr (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .inc_i(inc_ov),
    .limit_i(OV_LIMIT),
    .count_o(ov_cnt),
    .at_limit_o(ov_at)
  );

  tsr_attempt_ctr #(.W(5)) u_uv_ctr (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .inc_i(inc_uv),
    .limit_i(UV_LIMIT),
    .count_o(uv_cnt),
    .at_limit_o(uv_at)
  );

  assign tick = (s.pre == 32'h0);
  assign uv_alarm = (s.cfg.alarm_sel == ALM_ON) ||
                    ((s.cfg.alarm_sel == ALM_RUN_ONLY) && !stopping_i); // [R12]
  assign uv_blocked = uv_at && !s.cfg.unlimited; // [R3] [R13]
  // Below threshold, or method 01, the output starts from 0 Hz
  assign match_freq = ((s.cfg.method == METHOD_ZERO) || (motor_freq_i < s.cfg.thresh)) ?
                      16'h0000 : motor_freq_i; // [R5] [R8] [R15]

  always_comb
  begin
    next_s = s;
    inc_oc = 1'b0;
    inc_ov = 1'b0;
    inc_uv = 1'b0;
    next_s.drive.restart = 1'b0;
    next_s.rdata = 32'h0;
    next_s.pre = tick ? TICK_CYC[31:0] - 32'h1 : s.pre - 32'h1;

    if (wr_i)
    begin
      case (addr_i)
        ADDR_CTRL:
        begin
          next_s.cfg.method = wdata_i[CTRL_METHOD_LSB +: 2];
          next_s.cfg.alarm_sel = wdata_i[CTRL_ALARM_LSB +: 2];
          next_s.cfg.unlimited = wdata_i[CTRL_COUNT_BIT];
          next_s.cfg.phase_en = wdata_i[CTRL_PHASE_BIT];
        end
        // Out-of-range times are clamped, not rejected
        ADDR_RIDE:
        begin
          if (wdata_i < {28'h0, RIDE_MIN})
            next_s.cfg.ride = RIDE_MIN;
          else if (wdata_i > {28'h0, RIDE_MAX})
            next_s.cfg.ride = RIDE_MAX;
          else
            next_s.cfg.ride = wdata_i[3:0];
        end
        ADDR_WAIT:
        begin
          if (wdata_i < {22'h0, WAIT_MIN})
            next_s.cfg.wait_time = WAIT_MIN;
          else if (wdata_i > {22'h0, WAIT_MAX})
            next_s.cfg.wait_time = WAIT_MAX;
          else
            next_s.cfg.wait_time = wdata_i[9:0];
        end
        ADDR_THRESH:
        begin
          next_s.cfg.thresh = (wdata_i > {16'h0, THRESH_MAX}) ? THRESH_MAX : wdata_i[15:0];
        end
        default:
        begin
        end
      endcase
    end

    if (rd_i)
    begin
      case (addr_i)
        ADDR_CTRL:
          next_s.rdata = {26'h0, s.cfg.phase_en, s.cfg.unlimited, s.cfg.alarm_sel,
                          s.cfg.method};
        ADDR_RIDE:
          next_s.rdata = {28'h0, s.cfg.ride};
        ADDR_WAIT:
          next_s.rdata = {22'h0, s.cfg.wait_time};
        ADDR_THRESH:
          next_s.rdata = {16'h0, s.cfg.thresh};
        ADDR_STATUS:
          next_s.rdata = {1'b0, s.drive.trip_kind, 1'b0, s.st, 3'h0, uv_cnt, 3'h0, ov_cnt,
                          3'h0, oc_cnt};
        default:
          next_s.rdata = 32'h0;
      endcase
    end

    case (s.st)
      ST_RUN:
      begin
        if (faults_i.oc || faults_i.ov)
        begin
          next_s.drive.output_en = 1'b0;
          next_s.drive.trip_kind = faults_i.oc ? TRIP_OC : TRIP_OV;
          if (s.cfg.method == METHOD_ALARM)
          begin
            next_s.drive.alarm = 1'b1; // [R5]
            next_s.st = ST_ALARM;
          end
          else if (faults_i.oc ? oc_at : ov_at)
          begin
            next_s.drive.alarm = 1'b1;
            next_s.drive.locked = 1'b1; // [R1] [R2] [R4]
            next_s.st = ST_LOCK;
          end
          else
          begin
            inc_oc = faults_i.oc; // [R1] [R16]
            inc_ov = !faults_i.oc; // [R2] [R16]
            next_s.st = ST_CLEAR;
          end
        end
        else if (s.cfg.phase_en && faults_i.phase_loss)
        begin
          next_s.drive.output_en = 1'b0; // [R14]
          next_s.drive.alarm = 1'b1;
          next_s.drive.trip_kind = TRIP_PHASE;
          next_s.st = ST_ALARM;
        end
        else if (faults_i.uv)
        begin
          next_s.drive.output_en = 1'b0;
          next_s.drive.trip_kind = TRIP_UV;
          next_s.ride_cnt = 4'h0;
          next_s.st = ST_UV_RIDE;
        end
      end
      ST_UV_RIDE:
      begin
        if (faults_i.uv)
        begin
          if (tick && (s.ride_cnt >= s.cfg.ride))
          begin
            // Trips even with a restart method selected
            next_s.drive.alarm = uv_alarm; // [R9] [R12]
            next_s.st = ST_ALARM;
          end
          else if (tick)
          begin
            next_s.ride_cnt = s.ride_cnt + 4'h1;
          end
        end
        else if (s.cfg.method == METHOD_ALARM)
        begin
          next_s.drive.alarm = uv_alarm; // [R5] [R12]
          next_s.st = ST_ALARM;
        end
        else if (uv_blocked)
        begin
          next_s.drive.alarm = uv_alarm;
          next_s.drive.locked = 1'b1; // [R3] [R4]
          next_s.st = ST_LOCK;
        end
        else
        begin
          inc_uv = !s.cfg.unlimited; // [R10] [R13] [R16]
          next_s.wait_cnt = s.cfg.wait_time; // [R11]
          next_s.st = ST_WAIT;
        end
      end
      ST_CLEAR:
      begin
        if (!faults_i.oc && !faults_i.ov)
        begin
          next_s.wait_cnt = s.cfg.wait_time; // [R11]
          next_s.st = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (s.wait_cnt == 10'h0)
        begin
          next_s.drive.output_en = 1'b1;
          next_s.drive.restart = 1'b1;
          next_s.drive.start_freq = match_freq; // [R6] [R8] [R15]
          next_s.drive.decel_stop = (s.cfg.method == METHOD_MATCH_STOP); // [R7]
          next_s.st = (s.cfg.method == METHOD_MATCH_STOP) ? ST_DECEL : ST_RUN;
          if (s.cfg.method != METHOD_MATCH_STOP)
            next_s.drive.trip_kind = TRIP_NONE;
        end
        else if (tick)
        begin
          next_s.wait_cnt = s.wait_cnt - 10'h1; // [R11]
        end
      end
      ST_DECEL:
      begin
        if (stopped_i)
        begin
          next_s.drive.output_en = 1'b0;
          next_s.drive.decel_stop = 1'b0;
          next_s.drive.alarm = 1'b1; // [R7]
          next_s.st = ST_ALARM;
        end
      end
      ST_ALARM:
      begin
        if (fault_reset_i)
        begin
          next_s.drive.alarm = 1'b0;
          next_s.drive.trip_kind = TRIP_NONE;
          next_s.drive.output_en = 1'b1;
          next_s.drive.restart = 1'b1;
          next_s.drive.start_freq = 16'h0000;
          next_s.st = ST_RUN;
        end
      end
      ST_LOCK:
      begin
        // Only reset, i.e. a power cycle, leaves this state
        next_s.st = ST_LOCK; // [R4]
      end
      default:
      begin
        next_s.st = ST_LOCK;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s <= '0;
      s.st <= ST_RUN;
      s.cfg.ride <= RIDE_RST;
      s.cfg.wait_time <= WAIT_RST;
      s.cfg.thresh <= THRESH_RST;
      s.drive.output_en <= 1'b1;
      s.drive.trip_kind <= TRIP_NONE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign drive_o = s.drive;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  a_oc_limit_lock: assert property ( // [R1]
    (s.st == ST_RUN && faults_i.oc && s.cfg.method != METHOD_ALARM && oc_cnt == OC_LIMIT)
    |=> s.st == ST_LOCK && drive_o.locked)
    else $error("over-current limit did not lock");
  a_ov_limit_lock: assert property ( // [R2]
    (s.st == ST_RUN && !faults_i.oc && faults_i.ov && s.cfg.method != METHOD_ALARM &&
     ov_cnt == OV_LIMIT) |=> s.st == ST_LOCK)
    else $error("over-voltage limit did not lock");
  a_uv_count_cap: assert property ( // [R3]
    (s.st == ST_UV_RIDE && !faults_i.uv && s.cfg.method != METHOD_ALARM && !s.cfg.unlimited
     && uv_cnt == UV_LIMIT) |=> s.st == ST_LOCK)
    else $error("under-voltage limit did not lock");
  a_lock_holds: assert property ( // [R4]
    s.st == ST_LOCK |=> s.st == ST_LOCK && !drive_o.output_en && !drive_o.restart)
    else $error("left lock without reset");
  a_alarm_no_restart: assert property ( // [R5]
    (s.st == ST_RUN && (faults_i.oc || faults_i.ov) && s.cfg.method == METHOD_ALARM)
    |=> s.st == ST_ALARM && drive_o.alarm && !drive_o.output_en)
    else $error("method 00 did not alarm");
  a_match_freq: assert property ( // [R6]
    (s.st == ST_WAIT && s.wait_cnt == 10'h0 && s.cfg.method[1] && motor_freq_i >= s.cfg.thresh)
    |=> drive_o.restart && drive_o.start_freq == $past(motor_freq_i))
    else $error("matched restart frequency wrong");
  a_mode3_decel: assert property ( // [R7]
    (s.st == ST_DECEL && stopped_i) |=> s.st == ST_ALARM && drive_o.alarm && !drive_o.decel_stop)
    else $error("method 03 did not end in trip display");
  a_ride_trip: assert property ( // [R9]
    (s.st == ST_UV_RIDE && faults_i.uv && tick && s.ride_cnt >= s.cfg.ride)
    |=> s.st == ST_ALARM ##1 !drive_o.output_en)
    else $error("long under-voltage did not trip");
  a_uv_retry: assert property ( // [R10]
    (s.st == ST_UV_RIDE && !faults_i.uv && s.cfg.method != METHOD_ALARM && !uv_blocked)
    |=> s.st == ST_WAIT && s.wait_cnt == s.cfg.wait_time)
    else $error("short under-voltage did not retry");
  a_wait_no_early: assert property ( // [R11]
    (s.st == ST_WAIT && s.wait_cnt != 10'h0) |=> !drive_o.restart)
    else $error("restart before retry wait elapsed");
  a_uv_alarm_off: assert property ( // [R12]
    (s.st == ST_UV_RIDE && s.cfg.alarm_sel == ALM_OFF) |=> !drive_o.alarm)
    else $error("under-voltage alarm raised while disabled");
  a_phase_trip: assert property ( // [R14]
    (s.st == ST_RUN && !faults_i.oc && !faults_i.ov && faults_i.phase_loss)
    |=> (s.st == ST_ALARM) == $past(s.cfg.phase_en))
    else $error("phase loss handling wrong");
  a_zero_below: assert property ( // [R15]
    (s.st == ST_WAIT && s.wait_cnt == 10'h0 && motor_freq_i < s.cfg.thresh)
    |=> drive_o.start_freq == 16'h0000)
    else $error("slow motor not restarted at 0 Hz");
endmodule
`default_nettype wire

// ---- tsr_pkg.sv ----
// Shared constants and types of the trip auto-restart supervisor.
// Assumes one 250 MHz clock; times are held in 0.1 s ticks.
package tsr_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_PERIOD_MS = 100;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RIDE = 8'h04;
  localparam logic [7:0] ADDR_WAIT = 8'h08;
  localparam logic [7:0] ADDR_THRESH = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam int unsigned CTRL_METHOD_LSB = 0;
  localparam int unsigned CTRL_ALARM_LSB = 2;
  localparam int unsigned CTRL_COUNT_BIT = 4;
  localparam int unsigned CTRL_PHASE_BIT = 5;

  // Ride-through and retry wait in tenths of a second
  localparam logic [3:0] RIDE_RST = 4'ha;
  localparam logic [3:0] RIDE_MIN = 4'h3;
  localparam logic [3:0] RIDE_MAX = 4'ha;
  localparam logic [9:0] WAIT_RST = 10'h00a;
  localparam logic [9:0] WAIT_MIN = 10'h003;
  localparam logic [9:0] WAIT_MAX = 10'h3e8;
  // Threshold in 0.01 Hz, 0.00 to 400.0 Hz
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [15:0] THRESH_MAX = 16'h9c40;

  localparam logic [4:0] OC_LIMIT = 5'h03;
  localparam logic [4:0] OV_LIMIT = 5'h03;
  localparam logic [4:0] UV_LIMIT = 5'h10;

  localparam logic [1:0] METHOD_ALARM = 2'h0;
  localparam logic [1:0] METHOD_ZERO = 2'h1;
  localparam logic [1:0] METHOD_MATCH = 2'h2;
  localparam logic [1:0] METHOD_MATCH_STOP = 2'h3;

  localparam logic [1:0] ALM_OFF = 2'h0;
  localparam logic [1:0] ALM_ON = 2'h1;
  localparam logic [1:0] ALM_RUN_ONLY = 2'h2;

  typedef enum logic [2:0] {TRIP_NONE, TRIP_OC, TRIP_OV, TRIP_UV, TRIP_PHASE} tsr_trip_t;

  typedef enum logic [2:0] {
    ST_RUN, ST_UV_RIDE, ST_CLEAR, ST_WAIT, ST_DECEL, ST_ALARM, ST_LOCK
  } tsr_state_t;

  typedef struct packed {
    logic [1:0] method;
    logic [1:0] alarm_sel;
    logic unlimited;
    logic phase_en;
    logic [3:0] ride;
    logic [9:0] wait_time;
    logic [15:0] thresh;
  } tsr_cfg_t;

  typedef struct packed {
    logic oc;
    logic ov;
    logic uv;
    logic phase_loss;
  } tsr_faults_t;

  typedef struct packed {
    logic output_en;
    logic [15:0] start_freq;
    logic restart;
    logic decel_stop;
    logic alarm;
    logic locked;
    tsr_trip_t trip_kind;
  } tsr_drive_t;

endpackage

// ---- tsr_attempt_ctr.sv ----
// Restart attempt counter for one trip kind.
// Counts increment pulses and flags when the kind's limit is reached.
`timescale 1ns/1ps
`default_nettype none
module tsr_attempt_ctr #(
  parameter int unsigned W = 5
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic inc_i,
  input wire logic [W-1:0] limit_i,
  output logic [W-1:0] count_o,
  output logic at_limit_o
);
  typedef struct packed {
    logic [W-1:0] count;
  } tsr_ctr_t;

  tsr_ctr_t s;
  tsr_ctr_t next_s;

  always_comb
  begin
    next_s = s;
    if (inc_i && (s.count < limit_i))
    begin
      next_s.count = s.count + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign count_o = s.count;
  assign at_limit_o = (s.count >= limit_i);

  // Only a power cycle (reset) brings the count down again
  a_count_bounded: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R16]
    (s.count <= limit_i) and (inc_i && s.count < limit_i |=> s.count == $past(s.count) + 1'b1))
    else $error("attempt counter left its bound or missed an increment");
endmodule
`default_nettype wire

// ---- tsr_drive_model.sv ----
// Behavioural power stage and trip detectors facing the supervisor.
// Assumes the bench commands fault levels and motor speed; reacts to drive_i.
`timescale 1ns/1ps
`default_nettype none
module tsr_drive_model #(
  parameter int unsigned STOP_CYC = 6
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire tsr_pkg::tsr_faults_t fault_cmd_i,
  input wire logic [15:0] freq_cmd_i,
  input wire logic stopping_cmd_i,
  input wire tsr_pkg::tsr_drive_t drive_i,
  output tsr_pkg::tsr_faults_t faults_o,
  output logic [15:0] motor_freq_o,
  output logic stopping_o,
  output logic stopped_o
);
  import tsr_pkg::*;
  logic [7:0] decel_cnt;
  // Detectors report one cycle late, like a filtered comparator
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      faults_o <= '0;
      motor_freq_o <= '0;
      stopping_o <= 1'b0;
      stopped_o <= 1'b0;
      decel_cnt <= '0;
    end
    else
    begin
      faults_o <= fault_cmd_i;
      motor_freq_o <= freq_cmd_i;
      stopping_o <= stopping_cmd_i | drive_i.decel_stop;
      // Motor needs a few cycles to come to rest, never instantly
      decel_cnt <= drive_i.decel_stop ? decel_cnt + 8'h01 : 8'h00;
      stopped_o <= drive_i.decel_stop && (decel_cnt >= 8'(STOP_CYC));
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench of the trip auto-restart supervisor.
// Assumes a four-cycle tick so ride-through and retry times stay short.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tsr_pkg::*;
  localparam int unsigned TK = 4;
  localparam tsr_faults_t F_OC = 4'h8;
  localparam tsr_faults_t F_OV = 4'h4;
  localparam tsr_faults_t F_UV = 4'h2;
  localparam tsr_faults_t F_PH = 4'h1;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic fault_reset_i = 1'b0;
  logic [15:0] freq_cmd = 16'h0;
  logic stop_cmd = 1'b0;
  tsr_faults_t fcmd = 4'h0;
  logic [31:0] rdata_o;
  tsr_faults_t faults_i;
  logic [15:0] motor_freq_i;
  logic stopping_i;
  logic stopped_i;
  tsr_drive_t drive_o;
  int n_errors = 0;
  int checks = 0;
  int i;
  int n;
  always #2 clock_i = ~clock_i;
  tsr_supervisor #(.TICK_CYC(TK)) i_tsr_supervisor (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .faults_i(faults_i), .motor_freq_i(motor_freq_i), .stopping_i(stopping_i),
    .stopped_i(stopped_i), .fault_reset_i(fault_reset_i), .drive_o(drive_o));
  tsr_drive_model i_tsr_drive_model (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .fault_cmd_i(fcmd), .freq_cmd_i(freq_cmd), .stopping_cmd_i(stop_cmd), .drive_i(drive_o),
    .faults_o(faults_i), .motor_freq_o(motor_freq_i), .stopping_o(stopping_i),
    .stopped_o(stopped_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic power_cycle;
    rst_b_i <= 1'b0;
    fcmd <= 4'h0;
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk(rdata_o, exp);
  endtask
  task automatic setup(input logic [31:0] ctrl);
    wr_reg(ADDR_CTRL, ctrl);
    wr_reg(ADDR_WAIT, 32'h3);
    wr_reg(ADDR_RIDE, 32'h3);
  endtask
  // Bounded wait on restart (0), alarm (1) or lock (2)
  task automatic wait_sig(input int w, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    do
    begin
      @(negedge clock_i);
      cnt++;
      hit = (w == 0) ? drive_o.restart : (w == 1) ? drive_o.alarm : drive_o.locked;
      if (cnt > lim)
      begin
        n_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, hit, 1'b1);
        tally_and_finish();
      end
    end
    while (hit !== 1'b1);
  endtask
  task automatic pulse_fault(input tsr_faults_t f, input int hold);
    @(posedge clock_i);
    fcmd <= f;
    repeat (hold) @(posedge clock_i);
    fcmd <= 4'h0;
  endtask
  task automatic quiet(input int cyc);
    int seen;
    seen = 0;
    repeat (cyc) @(negedge clock_i) if (drive_o.restart === 1'b1) seen++;
    chk(seen, 0);
  endtask
  task automatic retry(input tsr_faults_t f, input int hold, input logic [15:0] sf);
    int c;
    pulse_fault(f, hold);
    wait_sig(0, 200, c);
    chk(32'(c >= 2 * TK && c <= 6 * TK), 32'h1);
    chk(drive_o.start_freq, sf);
    chk(drive_o.output_en, 1'b1);
  endtask
  task automatic clear_alarm;
    int c;
    @(posedge clock_i);
    fault_reset_i <= 1'b1;
    @(posedge clock_i);
    fault_reset_i <= 1'b0;
    wait_sig(0, 20, c);
    chk(drive_o.alarm, 1'b0);
  endtask
  initial
  begin
    power_cycle();
    chk(drive_o, {1'b1, 16'h0, 4'h0, TRIP_NONE});
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_RIDE, 32'ha);
    rd_chk(ADDR_WAIT, 32'ha);
    rd_chk(ADDR_THRESH, 32'h0);
    rd_chk(8'h14, 32'h0);
    wr_reg(ADDR_STATUS, 32'hffff);
    rd_chk(ADDR_STATUS, 32'h0);
    wr_reg(ADDR_RIDE, 32'h1);
    rd_chk(ADDR_RIDE, 32'h3);
    wr_reg(ADDR_WAIT, 32'hffff);
    rd_chk(ADDR_WAIT, 32'h3e8);
    wr_reg(ADDR_THRESH, 32'hffff);
    rd_chk(ADDR_THRESH, 32'h9c40);
    // Method 00 alarms and never restarts
    pulse_fault(F_OC, 3);
    wait_sig(1, 20, n);
    quiet(40);
    clear_alarm();
    // Over-current, 0 Hz restart, fourth trip locks
    setup(32'h1);
    // Threshold at 0 so only method 01 can force the 0 Hz start
    wr_reg(ADDR_THRESH, 32'h0);
    freq_cmd <= 16'h1388;
    for (i = 0; i < 3; i++)
      retry(F_OC, 3, 16'h0);
    pulse_fault(F_OC, 3);
    wait_sig(2, 20, n);
    quiet(60);
    chk(drive_o.output_en, 1'b0);
    rd_chk(ADDR_STATUS, 32'h16000003);
    // Over-voltage with matching and the 0 Hz threshold
    power_cycle();
    setup(32'h2);
    wr_reg(ADDR_THRESH, 32'h1000);
    retry(F_OV, 3, 16'h1388);
    freq_cmd <= 16'h0800;
    retry(F_OV, 3, 16'h0);
    freq_cmd <= 16'h1388;
    retry(F_OV, 3, 16'h1388);
    pulse_fault(F_OV, 3);
    wait_sig(2, 20, n);
    rd_chk(ADDR_STATUS, 32'h26000300);
    // Method 03: match, resume, decelerate, then show trip
    power_cycle();
    setup(32'h3);
    retry(F_OV, 3, 16'h1388);
    @(negedge clock_i);
    chk(drive_o.decel_stop, 1'b1);
    wait_sig(1, 40, n);
    chk(drive_o.output_en, 1'b0);
    clear_alarm();
    // Short under-voltage retries, seventeenth locks unless the count is unlimited
    power_cycle();
    setup(32'h1);
    for (i = 0; i < 16; i++)
      retry(F_UV, 2, 16'h0);
    pulse_fault(F_UV, 2);
    wait_sig(2, 20, n);
    rd_chk(ADDR_STATUS, 32'h36100000);
    power_cycle();
    setup(32'h11);
    for (i = 0; i < 17; i++)
      retry(F_UV, 2, 16'h0);
    chk(drive_o.locked, 1'b0);
    // Long under-voltage trips; alarm follows the selection code
    for (i = 0; i < 4; i++)
    begin
      wr_reg(ADDR_CTRL, {26'h0, 2'h1, 2'(i > 1 ? 2 : i), METHOD_ZERO});
      stop_cmd <= (i == 2);
      pulse_fault(F_UV, 40);
      repeat (2) @(negedge clock_i);
      chk(drive_o.alarm, 1'(i != 0 && i != 2));
      chk(drive_o.output_en, 1'b0);
      chk(drive_o.trip_kind, TRIP_UV);
      stop_cmd <= 1'b0;
      clear_alarm();
    end
    // Phase loss ignored unless enabled
    pulse_fault(F_PH, 5);
    @(negedge clock_i);
    chk(drive_o.output_en, 1'b1);
    wr_reg(ADDR_CTRL, 32'h21);
    pulse_fault(F_PH, 5);
    wait_sig(1, 20, n);
    chk(drive_o.trip_kind, TRIP_PHASE);
    clear_alarm();
    tally_and_finish();
  end
endmodule
`default_nettype wire
